// [shared/upbmc_defs.vh]
// Constants for the BMC codec: timing counts and channel select codes.
// Assumes a 200 MHz core clock; included by the design files by bare name.
`ifndef UPBMC_DEFS_VH
`define UPBMC_DEFS_VH

// Core clock period in picoseconds
`define UPBMC_CLK_PS 5000
// Nominal bit period in picoseconds (300 kbit/s, about 3333 ns)
`define UPBMC_BIT_PS 3333333
// Half-bit count in clock cycles, rounded down
`define UPBMC_HALF_CYC ((`UPBMC_BIT_PS / 2) / `UPBMC_CLK_PS)
// Default divider value loaded at reset
`define UPBMC_DIV_RST 10'h14d
// Width of the divider counter; the receive interval counter is two bits wider
`define UPBMC_CW 10
// Idle time with no transition before the bus counts as idle, in ns
`define UPBMC_IDLE_NS 12000
// Idle count in cycles
`define UPBMC_IDLE_CYC ((`UPBMC_IDLE_NS * 1000) / `UPBMC_CLK_PS)
// Width of the idle counter
`define UPBMC_IW 12
// Preamble low lead-in in half-bit units
`define UPBMC_LEAD_HB 2'h2
// Release hold after closing edge, in half-bits
`define UPBMC_TAIL_HB 2'h1
// Channel select codes
`define UPBMC_CH1 1'b0
`define UPBMC_CH2 1'b1

`endif

// [rtl/upbmc_rx.v]
// BMC receive decoder: classifies intervals between edges and yields bits.
// Assumes rx_level is already synchronised to clk and half_div is stable.
`timescale 1ns/100ps
`include "upbmc_defs.vh"

module upbmc_rx (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Timing
	input wire [`UPBMC_CW-1:0] half_div,
	// Line
	input wire rx_level,
	input wire rx_en,
	// Decoded bits
	output reg rx_bit_q,
	output reg rx_bit_valid_q,
	output reg rx_active_q
);

	reg prev_q; // Previous line level for edge detection
	reg [`UPBMC_CW+1:0] cnt_q; // Cycles since last edge
	reg half_seen_q; // Mid-bit edge already seen in this bit
	reg locked_q; // A boundary reference has been found
	wire edge_w;
	wire [`UPBMC_CW+1:0] thr_w;

	assign edge_w = rx_level ^ prev_q;
	// Three quarters of a bit is one and a half half-bits
	assign thr_w = {2'h0, half_div} + {3'h0, half_div[`UPBMC_CW-1:1]}; // RULE14

	// Edge interval classification
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			prev_q <= 1'b0;
			cnt_q <= {(`UPBMC_CW+2){1'b0}};
			half_seen_q <= 1'b0;
			locked_q <= 1'b0;
			rx_bit_q <= 1'b0;
			rx_bit_valid_q <= 1'b0;
			rx_active_q <= 1'b0;
		end else begin
			prev_q <= rx_level;
			rx_bit_valid_q <= 1'b0;
			if (!rx_en) begin
				// Own transmission or disabled: forget lock
				locked_q <= 1'b0;
				half_seen_q <= 1'b0;
				rx_active_q <= 1'b0;
				cnt_q <= {(`UPBMC_CW+2){1'b0}};
			end else if (edge_w) begin
				cnt_q <= {(`UPBMC_CW+2){1'b0}};
				if (!locked_q) begin
					// Any edge may serve as first reference, so a lost first edge is harmless
					locked_q <= 1'b1; // RULE5
					rx_active_q <= 1'b1;
				end else if (cnt_q >= thr_w) begin
					// Full-bit gap: boundary after boundary, a zero
					rx_bit_q <= 1'b0; // RULE1
					rx_bit_valid_q <= 1'b1;
					half_seen_q <= 1'b0;
				end else if (half_seen_q) begin
					// Second short gap closes a one
					rx_bit_q <= 1'b1; // RULE2
					rx_bit_valid_q <= 1'b1;
					half_seen_q <= 1'b0;
				end else begin
					half_seen_q <= 1'b1; // Mid-bit edge
				end
			end else if (cnt_q[`UPBMC_CW+1:1] > {1'b0, half_div}) begin
				// No edge for over two half-bits: packet is over
				locked_q <= 1'b0;
				half_seen_q <= 1'b0;
				rx_active_q <= 1'b0;
			end else begin
				cnt_q <= cnt_q + {{(`UPBMC_CW+1){1'b0}}, 1'b1};
			end
		end
	end

endmodule

// [rtl/upbmc_phy.v]
// BMC physical layer codec: transmit encoder, pin steering and squelch.
// Assumes the link layer supplies bits with a one-cycle handshake and that
// the channel choice and overvoltage flags come from the attach circuits.
`timescale 1ns/100ps
`include "upbmc_defs.vh"

// How it works
// RULE1 - Every bit starts with a line transition
// RULE2 - A one adds a mid-bit transition
// RULE3 - Stream stays within half-bit disparity
// RULE4 - Preamble starts by driving low
// RULE5 - Receiver locks despite missing first edge
// RULE6 - One closing edge after end-of-packet
// RULE7 - Driver enabled only while sending
// RULE8 - Data rides on the biased channel pin
// RULE9 - Channel pin fixed for whole connection
// RULE10 - Only one driver; others stay high-impedance
// RULE11 - Squelch reports bus idle
// RULE12 - Overvoltage forces the driver off
// RULE13 - Half-bit timing from programmable divider
// RULE14 - Intervals split at three-quarter bit
module upbmc_phy (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Configuration
	input wire [`UPBMC_CW-1:0] half_div,
	// Connection state
	input wire attached,
	input wire chan_sel,
	input wire cc1_ovp,
	input wire cc2_ovp,
	// Transmit request and bit stream
	input wire tx_start,
	input wire tx_bit,
	input wire tx_last,
	output wire tx_bit_ready,
	output reg tx_busy_q,
	// Received bit stream
	output wire rx_bit,
	output wire rx_bit_valid,
	output wire rx_active,
	// Squelch
	output reg bus_idle_q,
	// Channel pin 1
	input wire cc1_in,
	output reg cc1_out_q,
	output reg cc1_oe_n_q,
	// Channel pin 2
	input wire cc2_in,
	output reg cc2_out_q,
	output reg cc2_oe_n_q
);

	// Transmit states, one-hot
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_LEAD = 5'h02;
	localparam [4:0] ST_BIT = 5'h04;
	localparam [4:0] ST_CLOSE = 5'h08;
	localparam [4:0] ST_TAIL = 5'h10;

	reg [4:0] state_q; // Transmit state
	reg [4:0] state_d;
	reg [`UPBMC_CW-1:0] div_q; // Half-bit divider count
	reg [`UPBMC_CW-1:0] div_d;
	reg [`UPBMC_CW-1:0] div_lat_q; // Divider value latched per packet
	reg [`UPBMC_CW-1:0] div_lat_d;
	reg level_q; // Encoder output level
	reg level_d;
	reg second_q; // In second half of the bit
	reg second_d;
	reg bit_q; // Bit being sent
	reg bit_d;
	reg last_q; // Bit being sent is the last one
	reg last_d;
	reg [1:0] hb_q; // Half-bit counter for lead-in and tail
	reg [1:0] hb_d;
	reg drive_q; // Driver enable
	reg drive_d;
	reg take_d; // Accept the next bit from the source
	reg chan_q; // Channel pin locked for the connection
	reg [2:0] s1_q; // Three-stage synchroniser, pin 1
	reg [2:0] s2_q; // Three-stage synchroniser, pin 2
	reg rx1_q; // Debounced pin 1 level
	reg rx2_q; // Debounced pin 2 level
	reg [`UPBMC_IW-1:0] idle_q; // Cycles without a transition
	reg line_prev_q; // Previous selected level for squelch
	wire line_w; // Level of the selected pin
	wire ovp_w; // Either pin overvolted
	wire tick_w; // End of a half-bit

	// Guard the divider: zero would make every half-bit one cycle long
	// The count runs from the reload down to zero, so a level lasts reload+1 cycles
	function [`UPBMC_CW-1:0] upbmc_reload;
		input [`UPBMC_CW-1:0] d;
		begin
			upbmc_reload = (d == {`UPBMC_CW{1'b0}}) ? `UPBMC_DIV_RST : d;
		end
	endfunction

	assign ovp_w = cc1_ovp | cc2_ovp;
	assign tick_w = (div_q == {`UPBMC_CW{1'b0}});
	assign line_w = (chan_q == `UPBMC_CH2) ? rx2_q : rx1_q; // RULE8
	assign tx_bit_ready = take_d;

	// Channel is captured while detached and frozen while attached
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			chan_q <= `UPBMC_CH1;
		end else if (!attached) begin
			chan_q <= chan_sel; // RULE9
		end
	end

	// Pin synchronisers; a change counts when stages two and three agree
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			rx1_q <= 1'b0;
			rx2_q <= 1'b0;
		end else begin
			s1_q <= {s1_q[1:0], cc1_in};
			s2_q <= {s2_q[1:0], cc2_in};
			if (s1_q[1] == s1_q[2]) begin
				rx1_q <= s1_q[2];
			end
			if (s2_q[1] == s2_q[2]) begin
				rx2_q <= s2_q[2];
			end
		end
	end

	// Encoder next state
	always @* begin
		state_d = state_q;
		div_d = div_q;
		div_lat_d = div_lat_q;
		level_d = level_q;
		second_d = second_q;
		bit_d = bit_q;
		last_d = last_q;
		hb_d = hb_q;
		drive_d = drive_q;
		take_d = 1'b0;
		if (!tick_w) begin
			div_d = div_q - 1'b1; // RULE13
		end else begin
			div_d = upbmc_reload(div_lat_q); // RULE13
		end
		case (state_q)
			ST_IDLE: begin
				drive_d = 1'b0; // RULE7
				if (tx_start && attached && !ovp_w) begin
					// Start low for the lead-in so the first edge is a rising one
					state_d = ST_LEAD;
					level_d = 1'b0; // RULE4
					drive_d = 1'b1;
					hb_d = `UPBMC_LEAD_HB;
					div_lat_d = half_div;
					div_d = upbmc_reload(half_div);
					take_d = 1'b1;
					bit_d = tx_bit;
					last_d = tx_last;
					second_d = 1'b0;
				end
			end
			ST_LEAD: begin
				if (tick_w) begin
					hb_d = hb_q - 2'h1;
					if (hb_q == 2'h1) begin
						state_d = ST_BIT;
						level_d = ~level_q; // RULE1
					end
				end
			end
			ST_BIT: begin
				if (tick_w) begin
					if (!second_q) begin
						second_d = 1'b1;
						// Ones toggle mid-bit; each half is equal, which bounds disparity
						if (bit_q) begin
							level_d = ~level_q; // RULE2 RULE3
						end
					end else begin
						second_d = 1'b0;
						level_d = ~level_q; // RULE1
						if (last_q) begin
							// That edge closes the final bit for the far receiver
							state_d = ST_CLOSE; // RULE6
							hb_d = `UPBMC_TAIL_HB;
						end else begin
							take_d = 1'b1;
							bit_d = tx_bit;
							last_d = tx_last;
						end
					end
				end
			end
			ST_CLOSE: begin
				if (tick_w) begin
					hb_d = hb_q - 2'h1;
					if (hb_q == 2'h1) begin
						state_d = ST_TAIL;
					end
				end
			end
			ST_TAIL: begin
				// Release the line so the attach bias returns
				drive_d = 1'b0; // RULE7 RULE10
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
				drive_d = 1'b0;
			end
		endcase
		if (ovp_w) begin
			// Overvoltage aborts any packet at once
			state_d = ST_IDLE; // RULE12
			drive_d = 1'b0; // RULE12
			take_d = 1'b0; // No bit is consumed in the cycle that aborts the packet
		end
	end

	// Encoder registers
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= ST_IDLE;
			div_q <= `UPBMC_DIV_RST;
			div_lat_q <= `UPBMC_DIV_RST;
			level_q <= 1'b0;
			second_q <= 1'b0;
			bit_q <= 1'b0;
			last_q <= 1'b0;
			hb_q <= 2'h0;
			drive_q <= 1'b0;
			tx_busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			div_q <= div_d;
			div_lat_q <= div_lat_d;
			level_q <= level_d;
			second_q <= second_d;
			bit_q <= bit_d;
			last_q <= last_d;
			hb_q <= hb_d;
			drive_q <= drive_d;
			tx_busy_q <= (state_d != ST_IDLE);
		end
	end

	// Pin drive: only the locked channel is ever enabled
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			cc1_out_q <= 1'b0;
			cc2_out_q <= 1'b0;
			cc1_oe_n_q <= 1'b1;
			cc2_oe_n_q <= 1'b1;
		end else begin
			cc1_out_q <= level_d;
			cc2_out_q <= level_d;
			cc1_oe_n_q <= ~(drive_d && chan_q == `UPBMC_CH1); // RULE7 RULE8
			cc2_oe_n_q <= ~(drive_d && chan_q == `UPBMC_CH2); // RULE7 RULE8
		end
	end

	// Squelch: idle once no transition is seen for the idle time
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			idle_q <= {`UPBMC_IW{1'b0}};
			line_prev_q <= 1'b0;
			bus_idle_q <= 1'b0;
		end else begin
			line_prev_q <= line_w;
			// Drop the idle report on the same edge that enables the driver
			if ((line_w != line_prev_q) || drive_q || drive_d) begin
				idle_q <= {`UPBMC_IW{1'b0}};
				bus_idle_q <= 1'b0; // RULE11
			end else if (idle_q == `UPBMC_IDLE_CYC) begin
				bus_idle_q <= 1'b1; // RULE11
			end else begin
				idle_q <= idle_q + 1'b1;
			end
		end
	end

	// Receiver listens on the locked pin, and not to its own packets
	upbmc_rx u_rx (
		.clk(clk),
		.reset(reset),
		.half_div(half_div), // RULE14
		.rx_level(line_w),
		.rx_en(attached & ~drive_q), // RULE10
		.rx_bit_q(rx_bit),
		.rx_bit_valid_q(rx_bit_valid),
		.rx_active_q(rx_active) // RULE5
	);

endmodule

// [tb/upbmc_checker.sv]
// Checker for the BMC codec top: driver enable, lead-in and edge spacing.
// Assumes half_div is nonzero and steady while a packet is on the wire.
`timescale 1ns/100ps
module upbmc_checker (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Control
	input wire [9:0] half_div,
	input wire attached,
	input wire chan_sel,
	input wire cc1_ovp,
	input wire cc2_ovp,
	input wire tx_start,
	// Status
	input wire tx_busy_q,
	input wire bus_idle_q,
	// Pins
	input wire cc1_out_q,
	input wire cc1_oe_n_q,
	input wire cc2_out_q,
	input wire cc2_oe_n_q
);
	// Driving either pin, and the level on the driven pin
	wire drv_on = !cc1_oe_n_q || !cc2_oe_n_q;
	wire lvl = !cc1_oe_n_q ? cc1_out_q : cc2_out_q;
	reg ch_q, lvl_q, drv_q;
	reg [10:0] run_q;
	// Channel shadow moves only while detached; run_q is the age of the level
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ch_q <= 1'b0;
			lvl_q <= 1'b0;
			drv_q <= 1'b0;
			run_q <= 11'h000;
		end else begin
			if (!attached)
				ch_q <= chan_sel;
			lvl_q <= lvl;
			drv_q <= drv_on;
			run_q <= (!drv_on || lvl != lvl_q) ? 11'h000 : run_q + 11'h001;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_take;
		tx_start && !tx_busy_q && attached && !cc1_ovp && !cc2_ovp;
	endsequence
	sequence s_lead;
		tx_busy_q && drv_on && !lvl;
	endsequence
	property p_start;
		s_take |=> s_lead;
	endproperty
	property p_ovp;
		(cc1_ovp || cc2_ovp) |=> !drv_on;
	endproperty
	property p_one;
		!(!cc1_oe_n_q && !cc2_oe_n_q);
	endproperty
	property p_busy;
		drv_on |-> tx_busy_q;
	endproperty
	property p_rel;
		$fell(tx_busy_q) |-> !drv_on;
	endproperty
	property p_idle;
		bus_idle_q |-> !drv_on;
	endproperty
	property p_pin;
		drv_on |-> (!cc2_oe_n_q == ch_q);
	endproperty
	// Half bit, full bit, or the two-half-bit lead-in
	property p_half;
		(drv_on && drv_q && lvl != lvl_q && half_div != 10'h000) |->
			(run_q == {1'b0, half_div} || run_q == {half_div, 1'b1}
			|| run_q == {half_div, 1'b0} + 11'h002);
	endproperty
	a_start: assert property (p_start) else $error("lead");
	a_ovp: assert property (p_ovp) else $error("ovp");
	a_one: assert property (p_one) else $error("two drivers");
	a_busy: assert property (p_busy) else $error("idle drive");
	a_rel: assert property (p_rel) else $error("release");
	a_idle: assert property (p_idle) else $error("idle");
	a_pin: assert property (p_pin) else $error("pin");
	a_half: assert property (p_half) else $error("spacing");
endmodule
bind upbmc_phy upbmc_checker chk (.clk, .reset, .half_div, .attached, .chan_sel,
	.cc1_ovp, .cc2_ovp, .tx_start, .tx_busy_q, .bus_idle_q, .cc1_out_q,
	.cc1_oe_n_q, .cc2_out_q, .cc2_oe_n_q);

// [tb/upbmc_partner.sv]
// Far-side partner: sends BMC frames on the wire, then lets go.
// Assumes the bench resolves the wire; a released wire sits at the low bias.
`timescale 1ns/100ps
module upbmc_partner #(parameter HALF = 4) (
	// Clock
	input wire clk,
	// Drive enable and level
	output reg p_oe,
	output reg p_lvl
);
	initial begin
		p_oe = 1'b0;
		p_lvl = 1'b0;
	end
	// Low lead-in, bits MSB first, closing edge; skip loses the first edge
	task send(input [15:0] bits, input skip);
		integer i;
		begin
			p_lvl = 1'b0;
			p_oe = !skip;
			repeat (2 * HALF) @(negedge clk);
			for (i = 15; i >= 0; i = i - 1) begin
				if (i == 15 && skip)
					p_oe = 1'b1;
				else
					p_lvl = !p_lvl;
				repeat (HALF) @(negedge clk);
				if (bits[i])
					p_lvl = !p_lvl;
				repeat (HALF) @(negedge clk);
			end
			p_lvl = !p_lvl;
			repeat (HALF) @(negedge clk);
			p_oe = 1'b0;
		end
	endtask
endmodule

// [tb/tb_top.sv]
// Bench for the BMC codec: packets out on each pin, frames in, abort, squelch.
// Assumes the partner and the bound checker are compiled first.
`timescale 1ns/100ps
module tb_top;
	reg clk = 1'b0, reset = 1'b1, attached = 1'b0, chan_sel = 1'b1, pp = 1'b0;
	reg cc1_ovp = 1'b0, cc2_ovp = 1'b0, tx_start = 1'b0, tx_bit = 1'b0, tx_last = 1'b0;
	reg used1 = 1'b0, used2 = 1'b0, lvl_q = 1'b0;
	reg [9:0] half_div = 10'h003;
	reg [7:0] rx_sr = 8'h00;
	integer failures = 0, n_tests = 0, tog = 0;
	wire tx_bit_ready, tx_busy_q, rx_bit, rx_bit_valid, rx_active, bus_idle_q;
	wire cc1_out_q, cc1_oe_n_q, cc2_out_q, cc2_oe_n_q, p_oe, p_lvl;
	// Wire: our driver, else the partner, else the low bias
	wire cc1_in = !cc1_oe_n_q ? cc1_out_q : (p_oe && !pp) ? p_lvl : 1'b0;
	wire cc2_in = !cc2_oe_n_q ? cc2_out_q : (p_oe && pp) ? p_lvl : 1'b0;
	// Level we put on the wire; a released wire sits at the low bias
	wire lvl = !cc1_oe_n_q ? cc1_out_q : !cc2_oe_n_q ? cc2_out_q : 1'b0;
	upbmc_phy dut (.clk, .reset, .half_div, .attached, .chan_sel, .cc1_ovp, .cc2_ovp,
		.tx_start, .tx_bit, .tx_last, .tx_bit_ready, .tx_busy_q, .rx_bit, .rx_bit_valid,
		.rx_active, .bus_idle_q, .cc1_in, .cc1_out_q, .cc1_oe_n_q, .cc2_in, .cc2_out_q,
		.cc2_oe_n_q);
	upbmc_partner #(.HALF(4)) far (.clk, .p_oe, .p_lvl);
	initial begin
		forever #2.5 clk = ~clk;
	end
	// Decoded bits, edges we drive, and which pins we drove
	always @(posedge clk) begin
		if (rx_bit_valid)
			rx_sr <= {rx_sr[6:0], rx_bit};
		if (!cc1_oe_n_q || !cc2_oe_n_q)
			tog <= tog + (lvl != lvl_q);
		lvl_q <= lvl;
		used1 <= used1 | !cc1_oe_n_q;
		used2 <= used2 | !cc2_oe_n_q;
	end
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task summarize;
		begin
			$display("compares %0d failures %0d", n_tests, failures);
			if (failures == 0 && n_tests > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// One byte MSB first; edges = bit starts + ones + closing edge
	task tx(input [7:0] b, input [1:0] pin);
		integer i, g;
		reg take;
		begin
			tog = 0;
			used1 = 0;
			used2 = 0;
			i = 0;
			g = 0;
			tx_start = 1'b1;
			tx_bit = b[7];
			tx_last = 1'b0;
			while (i < 8 && g < 400) begin
				#1 take = tx_bit_ready;
				@(negedge clk);
				tx_start = 1'b0;
				g = g + 1;
				if (take) begin
					i = i + 1;
					tx_bit = b[(7 - i) & 7];
					tx_last = (i == 7);
				end
			end
			while (tx_busy_q && g < 800) begin
				@(negedge clk);
				g = g + 1;
			end
			@(negedge clk);
			chk(tog, 9 + $countones(b));
			chk({used2, used1}, pin);
			chk({cc1_oe_n_q, cc2_oe_n_q, tx_busy_q}, 3'b110);
			$display("packet %h done", b);
		end
	endtask
	// Partner frame with a preamble; the last byte must come out
	task rx(input [7:0] b, input skip);
		begin
			used1 = 0;
			used2 = 0;
			pp = chan_sel;
			far.send({8'h55, b}, skip);
			chk(rx_active, 1);
			repeat (20) @(negedge clk);
			chk(rx_active, 0);
			chk(rx_sr, b);
			chk({used2, used1}, 2'b00);
			$display("frame %h done", b);
		end
	endtask
	initial begin
		#200000;
		failures = failures + 1;
		summarize;
	end
	initial begin
		repeat (4) @(negedge clk);
		reset = 1'b0;
		chk({cc1_oe_n_q, cc2_oe_n_q, tx_busy_q}, 3'b110);
		// Start while detached is ignored
		tx_start = 1'b1;
		@(negedge clk);
		tx_start = 1'b0;
		repeat (3) @(negedge clk);
		chk({cc1_oe_n_q, cc2_oe_n_q, tx_busy_q}, 3'b110);
		$display("reset done");
		// Attach on pin 2, then move chan_sel: pin 2 must stay
		attached = 1'b1;
		@(negedge clk);
		chan_sel = 1'b0;
		tx(8'ha5, 2'b10);
		tx(8'h00, 2'b10);
		attached = 1'b0;
		@(negedge clk);
		attached = 1'b1;
		tx(8'hff, 2'b01);
		// Overvoltage in mid-packet
		tx_bit = 1'b1;
		tx_last = 1'b0;
		tx_start = 1'b1;
		@(negedge clk);
		tx_start = 1'b0;
		repeat (20) @(negedge clk);
		chk(cc1_oe_n_q, 0);
		cc1_ovp = 1'b1;
		@(negedge clk);
		chk({cc1_oe_n_q, cc2_oe_n_q}, 2'b11);
		repeat (20) @(negedge clk);
		chk(tx_busy_q, 0);
		cc1_ovp = 1'b0;
		$display("abort done");
		rx(8'h6c, 1'b1);
		rx(8'h93, 1'b0);
		// Squelch
		chk(bus_idle_q, 0);
		repeat (2375) @(negedge clk);
		chk(bus_idle_q, 0);
		repeat (30) @(negedge clk);
		chk(bus_idle_q, 1);
		$display("squelch done");
		// Sending again must leave the idle report dropped once the packet ends
		tx(8'h3c, 2'b01);
		chk(bus_idle_q, 0);
		$display("idle drop done");
		summarize;
	end
endmodule
